// ---- sao_params.svh ----
/*
 Register offsets, field positions and reset values of the servo alarm
 code output block. Assumes inclusion by bare name from design files.
*/
`ifndef SAO_PARAMS_SVH
`define SAO_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SAO_OFF_CTRL    8'h00
`define SAO_OFF_SPDLIM  8'h04
`define SAO_OFF_ALMSTAT 8'h08
`define SAO_OFF_IRQSTAT 8'h0c
`define SAO_OFF_IRQCLR  8'h10
`define SAO_OFF_IRQEN   8'h14
`define SAO_OFF_ALMCLR  8'h18

// ----------------------------------------------------------------------
// Field positions, reset values, warning id range and response codes
// ----------------------------------------------------------------------
`define SAO_CTRL_CODEEN  0
`define SAO_CTRL_TORQUE  1
`define SAO_ALMCLR_SET   0
`define SAO_IRQ_ALARM    0
`define SAO_IRQ_CLEARED  1
`define SAO_IRQ_WARN     2
`define SAO_CTRL_RST     2'h0
`define SAO_SPDLIM_RST   16'h0000
`define SAO_IRQEN_RST    3'h0
`define SAO_WARN_LO      8'he0
`define SAO_WARN_HI      8'he9
`define SAO_RESP_OKAY    2'h0
`define SAO_RESP_SLVERR  2'h2

`endif

// ---- sao_pkg.sv ----
/*
 Types shared by the servo alarm code output block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sao_pkg;

   // Code on pins 10/11/12 and the clearing methods an alarm accepts
   typedef struct packed {
      logic [2:0] code;
      logic       clrByReset;
      logic       clrBySet;
   } sao_alm_info_t;

   typedef struct packed {
      logic zeroSpeed;
      logic speedReached;
   } sao_status_t;

   typedef struct packed {
      logic fwdStart;
      logic revStart;
      logic torqueCmdZero;
   } sao_torque_in_t;

   typedef enum logic [0:0] {
      SAO_IDLE    = 1'b0,
      SAO_LATCHED = 1'b1
   } sao_alm_state_t;

endpackage

// ---- sao_alarm_top.sv ----
/*
 Alarm signalling of a servo amplifier interface with an AXI4-Lite
 register slave. Assumes synchronous inputs on mclk and a single
 outstanding write and read on the bus.
*/
`timescale 1ns/10ps
`include "sao_params.svh"

module sao_alarm_top (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   // AXI4-Lite slave
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Fault detection
   input  wire logic                   faultRaise,
   input  wire logic [7:0]             faultId,
   input  wire logic                   faultPresent,
   input  wire logic                   alarmResetIn,
   // Machine status and commands
   input  wire logic                   servoEnableIn,
   input  wire sao_pkg::sao_status_t   statusIn,
   input  wire sao_pkg::sao_torque_in_t torqueIn,
   // Outputs
   output logic                        faultOut,
   output logic [2:0]                  codePins,
   output logic                        servoLock,
   output logic                        motorRunEn,
   output logic                        irq
);
   import sao_pkg::*;

   // -------------------------------------------------------------------
   // Alarm table: code {pin10,pin11,pin12} and clearing methods
   // -------------------------------------------------------------------
   // Power cycling clears every alarm, so it needs no flag here.
   function automatic sao_alm_info_t almLookup(input logic [7:0] id);
      sao_alm_info_t r;
      r = '{code: 3'h0, clrByReset: 1'b0, clrBySet: 1'b0};
      unique case (id)
         8'h10: r = '{3'h2, 1'b1, 1'b1};
         8'h16, 8'h1a: r.code = 3'h5;
         8'h20: r.code = 3'h6;
         8'h24: r.code = 3'h1;
         8'h30, 8'h33: r = '{3'h2, id == 8'h30, id == 8'h30};
         8'h31: r = '{3'h3, 1'b1, 1'b1};
         8'h32: r = '{3'h1, 1'b1, 1'b1};
         8'h45, 8'h46, 8'h50, 8'h51: r = '{3'h6, 1'b1, 1'b1};
         8'h8a, 8'h8e: r = '{3'h0, 1'b1, 1'b1};
         default: r.code = 3'h0;
      endcase
      return r;
   endfunction
   logic           isWarn;
   sao_alm_info_t  newInfo;
   assign isWarn  = (faultId >= `SAO_WARN_LO) && (faultId <= `SAO_WARN_HI);
   assign newInfo = almLookup(faultId);
   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic [1:0]     ctrl_q;
   logic [15:0]    spdLim_q;
   logic [2:0]     irqStat_q, irqEn_q, irqClrW;
   sao_alm_state_t almState_q;
   logic [7:0]     almId_q;
   sao_alm_info_t  almInfo_q;
   logic           warnSeen_q, resetPrev_q;
   logic           setReq, clearOk, latchEv, codeEn, torqueMode;
   assign codeEn     = ctrl_q[`SAO_CTRL_CODEEN];
   assign torqueMode = ctrl_q[`SAO_CTRL_TORQUE];
   // -------------------------------------------------------------------
   // AXI4-Lite write path
   // -------------------------------------------------------------------
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        awHave_q, wHave_q, doWrite, wrMapped;
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   assign wrMapped = (awAddr_q == `SAO_OFF_CTRL) ||
                     (awAddr_q == `SAO_OFF_SPDLIM) ||
                     (awAddr_q == `SAO_OFF_IRQCLR) ||
                     (awAddr_q == `SAO_OFF_IRQEN) ||
                     (awAddr_q == `SAO_OFF_ALMCLR);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awHave_q <= 1'b0;
         wHave_q  <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SAO_RESP_OKAY;
      end else begin
         s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? `SAO_RESP_OKAY : `SAO_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign setReq = doWrite && (awAddr_q == `SAO_OFF_ALMCLR) &&
                   wStrb_q[0] && wData_q[`SAO_ALMCLR_SET];
   assign irqClrW = (doWrite && awAddr_q == `SAO_OFF_IRQCLR && wStrb_q[0])
                    ? wData_q[2:0] : 3'h0;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q   <= `SAO_CTRL_RST;
         spdLim_q <= `SAO_SPDLIM_RST;
         irqEn_q  <= `SAO_IRQEN_RST;
      end else if (doWrite) begin
         if (awAddr_q == `SAO_OFF_CTRL && wStrb_q[0])
            ctrl_q <= wData_q[1:0];
         if (awAddr_q == `SAO_OFF_SPDLIM) begin
            if (wStrb_q[0]) spdLim_q[7:0]  <= wData_q[7:0];
            if (wStrb_q[1]) spdLim_q[15:8] <= wData_q[15:8];
         end
         if (awAddr_q == `SAO_OFF_IRQEN && wStrb_q[0])
            irqEn_q <= wData_q[2:0];
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read path
   // -------------------------------------------------------------------
   logic [31:0] rdMux;
   logic        rdMapped;
   always_comb begin
      rdMux    = 32'h0000_0000;
      rdMapped = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         `SAO_OFF_CTRL:    rdMux = {30'h0, ctrl_q};
         `SAO_OFF_SPDLIM:  rdMux = {16'h0, spdLim_q};
         `SAO_OFF_ALMSTAT: rdMux = {13'h0, almInfo_q.code, almId_q,
                                    6'h0, warnSeen_q, almState_q};
         `SAO_OFF_IRQSTAT: rdMux = {29'h0, irqStat_q};
         `SAO_OFF_IRQEN:   rdMux = {29'h0, irqEn_q};
         `SAO_OFF_IRQCLR, `SAO_OFF_ALMCLR: rdMux = 32'h0000_0000;
         default:          rdMapped = 1'b0;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SAO_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid &&
                          !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdMapped ? `SAO_RESP_OKAY : `SAO_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Alarm latch and clearing
   // -------------------------------------------------------------------
   // Clear is refused while the cause is still present; a new alarm in
   // the clearing cycle wins so that no alarm is lost.
   assign clearOk = (almState_q == SAO_LATCHED) && !faultPresent &&
                    ((setReq && almInfo_q.clrBySet) ||
                     (alarmResetIn && !resetPrev_q &&
                      almInfo_q.clrByReset));
   assign latchEv = faultRaise && !isWarn &&
                    ((almState_q == SAO_IDLE) || clearOk);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         almState_q  <= SAO_IDLE;
         almId_q     <= 8'h00;
         almInfo_q   <= '{3'h0, 1'b0, 1'b0};
         faultOut    <= 1'b1;
         resetPrev_q <= 1'b0;
         warnSeen_q  <= 1'b0;
      end else begin
         resetPrev_q <= alarmResetIn;
         warnSeen_q  <= faultRaise && isWarn ? 1'b1 :
                        (faultPresent ? warnSeen_q : 1'b0);
         unique case (almState_q)
            SAO_IDLE: begin
               if (latchEv) begin
                  almState_q <= SAO_LATCHED;
                  almId_q    <= faultId;
                  almInfo_q  <= almLookup(faultId);
                  faultOut   <= 1'b0;
               end
            end
            SAO_LATCHED: begin
               if (latchEv) begin
                  almId_q   <= faultId;
                  almInfo_q <= almLookup(faultId);
               end else if (clearOk) begin
                  almState_q <= SAO_IDLE;
                  faultOut   <= 1'b1;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Output pins, servo lock and torque-mode start
   // -------------------------------------------------------------------
   logic readyInt;
   assign readyInt = servoEnableIn && (almState_q == SAO_IDLE) && !latchEv;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         codePins   <= 3'h0;
         servoLock  <= 1'b0;
         motorRunEn <= 1'b0;
      end else begin
         if (codeEn && (latchEv || (almState_q == SAO_LATCHED && !clearOk)))
            codePins <= latchEv ? newInfo.code : almInfo_q.code;
         else
            codePins <= {statusIn.speedReached, readyInt,
                         statusIn.zeroSpeed};
         servoLock  <= readyInt;
         motorRunEn <= readyInt && (!torqueMode ||
                       (!torqueIn.torqueCmdZero &&
                        (torqueIn.fwdStart || torqueIn.revStart) &&
                        spdLim_q != 16'h0000));
      end
   end

   // -------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------
   logic [2:0] irqSet;
   assign irqSet = {faultRaise && isWarn, clearOk && !latchEv, latchEv};
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_q <= 3'h0;
         irq       <= 1'b0;
      end else begin
         irqStat_q <= (irqStat_q & ~irqClrW) | irqSet;
         irq       <= |(((irqStat_q & ~irqClrW) | irqSet) & irqEn_q);
      end
   end
   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_fault_opens: assert property (
      faultRaise && !isWarn |=> !faultOut)
      else $error("fault output not opened on alarm");
   chk_code_select: assert property (
      codeEn && almState_q == SAO_LATCHED |=>
      codePins == $past(almInfo_q.code) || $past(clearOk) ||
      $past(latchEv))
      else $error("code pins do not show the alarm code");
   chk_warn_nocode: assert property (
      almState_q == SAO_IDLE && !(faultRaise && !isWarn) |=>
      almState_q == SAO_IDLE && faultOut)
      else $error("warning latched an alarm");
   chk_code_prompt: assert property (
      codeEn && latchEv |=> codePins == $past(newInfo.code))
      else $error("alarm code late on pins");
   chk_normal_pins: assert property (
      rst_b && almState_q == SAO_IDLE && !latchEv |=>
      codePins == {$past(statusIn.speedReached), $past(readyInt),
                   $past(statusIn.zeroSpeed)})
      else $error("status signals missing from code pins");
   chk_clear_gated: assert property (
      almState_q == SAO_LATCHED && faultPresent |=>
      almState_q == SAO_LATCHED [*1] ##0 !faultOut)
      else $error("alarm cleared while cause present");
   chk_servo_free: assert property (
      !servoEnableIn |=> !servoLock && !motorRunEn)
      else $error("shaft locked without servo enable");
   chk_torque_stop: assert property (
      torqueMode && (torqueIn.torqueCmdZero ||
      !(torqueIn.fwdStart || torqueIn.revStart)) |=> !motorRunEn)
      else $error("motor runs without torque command or start");
   chk_speed_zero: assert property (
      torqueMode && spdLim_q == 16'h0000 |=> !motorRunEn)
      else $error("motor runs with zero speed limit");
   chk_latch_hold: assert property (
      !faultOut && !clearOk |=> !faultOut [*1])
      else $error("fault output released without clear");
   cov_alarm_code: cover property (codeEn && latchEv ##1 !faultOut);
   cov_set_clear:  cover property (setReq && clearOk ##1 faultOut);
   cov_torque_run: cover property (torqueMode && motorRunEn);
   cov_warn_seen:  cover property (faultRaise && isWarn ##1 warnSeen_q);

endmodule // sao_alarm_top

// ---- sao_host_model.sv ----
/*
 Behavioural host controller that faces the alarm block: it drops servo
 enable while the fault loop is open and drives the alarm reset input.
 Assumes it shares mclk and rst_b with the block.
*/
`timescale 1ns/10ps

module sao_host_model
   import sao_pkg::*;
#(
   parameter int COOL_CYCLES = 8
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // From the amplifier and from the bench
   input  wire logic faultOut,
   input  wire logic enableReq,
   input  wire logic clearReq,
   // Into the amplifier
   output logic      servoEnableIn,
   output logic      alarmResetIn
);
   // ---------------------------------------------------------------
   // Enable and clear handling
   // ---------------------------------------------------------------
   logic [7:0] coolCnt_q;

   // Enable stays withdrawn for as long as the loop is open
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         servoEnableIn <= 1'b0;
      else
         servoEnableIn <= enableReq & faultOut;
   end

   // Cooling wait scaled down to a few cycles to keep the run short
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         coolCnt_q    <= 8'h00;
         alarmResetIn <= 1'b0;
      end else if (!clearReq) begin
         coolCnt_q    <= 8'h00;
         alarmResetIn <= 1'b0;
      end else if (coolCnt_q < 8'(COOL_CYCLES)) begin
         coolCnt_q    <= coolCnt_q + 8'h01;
      end else begin
         alarmResetIn <= 1'b1;
      end
   end
endmodule // sao_host_model

// ---- tb_top.sv ----
/*
 Self-checking bench for the alarm code output block.
 Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/10ps
`include "sao_params.svh"

module tb_top;
   import sao_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int COOL = 8;
   logic           mclk = 1'b0, rst_b = 1'b0;
   logic [7:0]     awaddr = 8'h00, araddr = 8'h00, faultId = 8'h00;
   logic [31:0]    wdata = 32'h0, rdata;
   logic [3:0]     wstrb = 4'hf;
   logic           awvalid = 0, wvalid = 0, bready = 0;
   logic           arvalid = 0, rready = 0;
   logic           awready, wready, bvalid, arready, rvalid;
   logic [1:0]     bresp, rresp;
   logic           faultRaise = 0, faultPresent = 0;
   logic           enableReq = 0, clearReq = 0;
   logic           servoEnableIn, alarmResetIn, faultOut;
   logic           servoLock, motorRunEn, irq;
   logic [2:0]     codePins;
   sao_status_t    statusIn = 2'b01;
   sao_torque_in_t torqueIn = 3'b000;
   int             err_count = 0, compares = 0;

   always #5 mclk = ~mclk;

   sao_alarm_top dut_u (
      .mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .faultRaise(faultRaise), .faultId(faultId),
      .faultPresent(faultPresent), .alarmResetIn(alarmResetIn),
      .servoEnableIn(servoEnableIn), .statusIn(statusIn),
      .torqueIn(torqueIn), .faultOut(faultOut), .codePins(codePins),
      .servoLock(servoLock), .motorRunEn(motorRunEn), .irq(irq));

   sao_host_model #(.COOL_CYCLES(COOL)) host_u (
      .mclk(mclk), .rst_b(rst_b), .faultOut(faultOut),
      .enableReq(enableReq), .clearReq(clearReq),
      .servoEnableIn(servoEnableIn), .alarmResetIn(alarmResetIn));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Leaves the bench 1 ns past an edge, so outputs have settled
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   logic [1:0]     bresp_q;
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1;
      w = 1;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge mclk);
         if (aw && awready) begin
            aw = 0;
            awvalid <= 0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 0;
         end
      end while (!bvalid);
      bready <= 0;
      bresp_q = bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge mclk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge mclk);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   task automatic raise(input logic [7:0] id);
      @(posedge mclk);
      faultRaise <= 1;
      faultId <= id;
      faultPresent <= 1;
      @(posedge mclk);
      faultRaise <= 0;
      hold(2);
   endtask

   task automatic do_reset;
      @(posedge mclk);
      rst_b <= 0;
      repeat (4) @(posedge mclk);
      rst_b <= 1;
      hold(4);
   endtask

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      logic [31:0] d;
      logic [1:0]  r;
      check(faultOut, 1, "loop closed");
      check(codePins, 3'b110, "status pins");
      check(servoLock, 1, "locked when on");
      axi_rd(`SAO_OFF_SPDLIM, d, r);
      check(d, 0, "limit reset value");
      axi_rd(8'h1c, d, r);
      check(r, `SAO_RESP_SLVERR, "unmapped read");
      check(d, 0, "unmapped data");
      axi_wr(8'h1c, 32'h1);
      check(bresp_q, `SAO_RESP_SLVERR, "unmapped write");
      $display("test reset done");
   endtask

   task automatic test_alarm;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(`SAO_OFF_CTRL, 32'h1);
      axi_wr(`SAO_OFF_IRQEN, 32'h1);
      raise(8'h31);
      check(faultOut, 0, "loop open");
      check(codePins, 3'b011, "alarm code");
      check(irq, 1, "irq raised");
      axi_rd(`SAO_OFF_ALMSTAT, d, r);
      check(d, 32'h0003_3101, "alarm status");
      check(servoLock, 0, "enable dropped");
      axi_wr(`SAO_OFF_ALMCLR, 32'h1);
      hold(2);
      check(faultOut, 0, "cause present");
      @(posedge mclk);
      faultPresent <= 0;
      hold(4);
      check(codePins, 3'b011, "code held");
      axi_wr(`SAO_OFF_IRQEN, 32'h0);
      hold(2);
      check(irq, 0, "irq masked");
      axi_wr(`SAO_OFF_ALMCLR, 32'h1);
      hold(4);
      check(faultOut, 1, "key clear");
      check(codePins, 3'b110, "status back");
      axi_wr(`SAO_OFF_IRQCLR, 32'h1);
      axi_wr(`SAO_OFF_IRQEN, 32'h1);
      hold(2);
      check(irq, 0, "irq cleared");
      $display("test alarm done");
   endtask

   task automatic test_clear;
      logic [7:0] ids [3] = '{8'h32, 8'h50, 8'h12};
      logic [2:0] codes [3] = '{3'b001, 3'b110, 3'b000};
      for (int i = 0; i < 3; i++) begin
         axi_wr(`SAO_OFF_CTRL, 32'h1);
         raise(ids[i]);
         check(codePins, codes[i], "code");
         @(posedge mclk);
         faultPresent <= 0;
         clearReq <= 1;
         hold(COOL + 4);
         check(faultOut, i < 2, "reset input");
         @(posedge mclk);
         clearReq <= 0;
         if (i == 2) begin
            axi_wr(`SAO_OFF_ALMCLR, 32'h1);
            hold(2);
            check(faultOut, 0, "key refused");
            do_reset();
            check(faultOut, 1, "power clear");
         end
      end
      $display("test clear done");
   endtask

   task automatic test_warning;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(`SAO_OFF_CTRL, 32'h1);
      for (int i = 0; i < 2; i++) begin
         raise(i ? `SAO_WARN_HI : `SAO_WARN_LO);
         check(faultOut, 1, "warning loop");
         check(codePins, 3'b110, "no code");
         axi_rd(`SAO_OFF_ALMSTAT, d, r);
         check(d[1:0], 2'b10, "warning flag");
         @(posedge mclk);
         faultPresent <= 0;
      end
      $display("test warning done");
   endtask

   task automatic test_torque;
      sao_torque_in_t tin [4] = '{3'b100, 3'b010, 3'b111, 3'b000};
      axi_wr(`SAO_OFF_CTRL, 32'h3);
      axi_wr(`SAO_OFF_SPDLIM, 32'h0);
      @(posedge mclk);
      torqueIn <= 3'b100;
      hold(3);
      check(motorRunEn, 0, "zero limit");
      axi_wr(`SAO_OFF_SPDLIM, 32'h64);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         torqueIn <= tin[i];
         hold(3);
         check(motorRunEn, i < 2, "start, command");
      end
      @(posedge mclk);
      enableReq <= 0;
      torqueIn <= 3'b100;
      hold(4);
      check(servoLock, 0, "shaft free");
      check(motorRunEn, 0, "no run when off");
      $display("test torque done");
   endtask

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      do_reset();
      @(posedge mclk);
      enableReq <= 1;
      hold(4);
      test_reset();
      test_alarm();
      test_clear();
      @(posedge mclk);
      enableReq <= 1;
      hold(4);
      test_warning();
      test_torque();
      complete_run();
   end

   // Under 300 cycles are needed; allow over sixty times that
   initial begin
      #200000;
      err_count++;
      complete_run();
   end
endmodule // tb_top
